//--- logic/ilag_params.svh
/*
 * Constants of the interrupt link access guard: register offsets, field
 * positions, region selectors and reset values.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ILAG_PARAMS_SVH
`define ILAG_PARAMS_SVH

// ----------------------------------------------------------------------
// Widths of identities and fields
// ----------------------------------------------------------------------
`define ILAG_LINK_W 4
`define ILAG_STK_W 4
`define ILAG_ZONE_W 2
`define ILAG_PRIO_W 8
`define ILAG_ADDR_W 12

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ILAG_OFF_WARN 12'h000
`define ILAG_OFF_MAX 12'h004
`define ILAG_OFF_STAT 12'h008
`define ILAG_OFF_STKSEL 12'h00c

// ----------------------------------------------------------------------
// Region selectors (address bits 11:6 for maps, 11:8 for line tables)
// ----------------------------------------------------------------------
`define ILAG_RGN_LMAP 6'h01
`define ILAG_RGN_ZMAP 6'h02
`define ILAG_RGN_CFG 4'h1
`define ILAG_RGN_OPS 4'h2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ILAG_CFG_OWNER_LO 0
`define ILAG_CFG_CALLER_LO 4
`define ILAG_CFG_PRIO_LO 8
`define ILAG_OPS_EN 0
`define ILAG_OPS_FLAG 1
`define ILAG_OPS_OVF 2
`define ILAG_OPS_FORCE 8
`define ILAG_OPS_CLR 9
`define ILAG_OPS_OVCLR 10
`define ILAG_STAT_WARN 16
`define ILAG_STAT_MAX 17
`define ILAG_STAT_LOCK 18
`define ILAG_STKSEL_LOCK 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ILAG_WARN_RST 8'hff
`define ILAG_STKSEL_RST 4'h0

`endif

//--- logic/ilag_pkg.sv
/*
 * Types shared by the interrupt link access guard.
 * Assumes the constants header is on the include path.
 */
`include "ilag_params.svh"

package ilag_pkg;

    // ------------------------------------------------------------------
    // CPU execution phase, in its two-bit encoding
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ILAG_ST_MAIN,
        ILAG_ST_INT,
        ILAG_ST_RT,
        ILAG_ST_NMI
    } ilag_int_state_t;

    // ------------------------------------------------------------------
    // Link-to-stack map lifecycle
    // ------------------------------------------------------------------
    typedef enum logic {
        ILAG_MAP_OPEN,
        ILAG_MAP_LOCKED
    } ilag_map_state_t;

    // Context the CPU presents every cycle
    typedef struct packed {
        logic [`ILAG_LINK_W-1:0] cur_link;
        logic [`ILAG_LINK_W-1:0] caller_link;
        ilag_int_state_t int_state;
    } ilag_cpu_ctx_t;

    // Per-line configuration entry
    typedef struct packed {
        logic [`ILAG_LINK_W-1:0] owner;
        logic [`ILAG_LINK_W-1:0] caller;
        logic [`ILAG_PRIO_W-1:0] prio;
        logic [31:0] vector;
    } ilag_line_cfg_t;

endpackage

//--- logic/ilag_ecc_enc.sv
/*
 * Single-error-correcting Hamming encoder for stack frame words.
 * Assumes PW satisfies 2**PW >= DW + PW + 1; purely combinational.
 */
`timescale 1ns/1ps

module ilag_ecc_enc #(
    parameter int DW = 32,
    parameter int PW = 6
) (
    // Plain word
    input wire logic [DW-1:0] data,
    // Protected word
    output logic [DW+PW-1:0] code
);
    // ------------------------------------------------------------------
    // Place data at non-power-of-two positions, then fill check bits
    // ------------------------------------------------------------------
    always_comb begin
        logic [DW+PW:1] pos;
        logic par;
        int d;
        pos = '0;
        par = 1'b0;
        d = 0;
        for (int p = 1; p <= DW + PW; p++) begin
            if ((p & (p - 1)) != 0) begin
                pos[p] = data[d];
                d++;
            end
        end
        for (int i = 0; i < PW; i++) begin
            par = 1'b0;
            for (int p = 1; p <= DW + PW; p++) begin
                if (((p >> i) & 1) == 1) begin
                    par = par ^ pos[p];
                end
            end
            pos[1 << i] = par;
        end
        code = pos;
    end
endmodule

//--- logic/ilag_ecc_dec.sv
/*
 * Single-error-correcting Hamming decoder for stack frame words.
 * Assumes the matching encoder layout; purely combinational.
 */
`timescale 1ns/1ps

module ilag_ecc_dec #(
    parameter int DW = 32,
    parameter int PW = 6
) (
    // Protected word
    input wire logic [DW+PW-1:0] code,
    // Corrected word and error indication
    output logic [DW-1:0] data,
    output logic fixed
);
    // ------------------------------------------------------------------
    // Syndrome points at the failing position; flip it and unpack
    // ------------------------------------------------------------------
    always_comb begin
        logic [DW+PW:1] pos;
        logic [PW-1:0] synd;
        int d;
        pos = code;
        synd = '0;
        d = 0;
        data = '0;
        for (int p = 1; p <= DW + PW; p++) begin
            if (pos[p]) begin
                synd = synd ^ PW'(p);
            end
        end
        fixed = (synd != '0);
        for (int p = 1; p <= DW + PW; p++) begin
            if (PW'(p) == synd) begin
                pos[p] = ~pos[p];
            end
        end
        for (int p = 1; p <= DW + PW; p++) begin
            if ((p & (p - 1)) != 0) begin
                data[d] = pos[p];
                d++;
            end
        end
    end
endmodule

//--- logic/ilag_guard.sv
/*
 * Interrupt link access guard: per-line ownership, secure-root config,
 * link/stack/zone maps, hidden ECC-protected real-time context stack and
 * its warning and maximum levels, all behind an APB slave.
 * Assumes CPU and expander signals are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "ilag_params.svh"

module ilag_guard #(
    parameter int NLINE = 8,
    parameter int NLINK = 16,
    parameter int NSTACK = 16,
    parameter int RT_DEPTH = 16,
    parameter int SP_W = 8,
    parameter logic [`ILAG_LINK_W-1:0] ROOT_LINK = 4'h0
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ILAG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // CPU context and requests
    input wire ilag_pkg::ilag_cpu_ctx_t cpu_ctx,
    input wire logic [$clog2(NLINE)-1:0] isr_line,
    input wire logic std_int_req,
    input wire logic [`ILAG_ZONE_W-1:0] dbg_zone,
    // Interrupt line events and state
    input wire logic [NLINE-1:0] irq_event,
    output logic [NLINE-1:0] irq_pending,
    output logic [31:0] isr_vector,
    output logic caller_match,
    output logic std_int_take,
    output logic dbg_allow,
    // Real-time context stack
    input wire logic rt_push,
    input wire logic [31:0] rt_push_data,
    input wire logic rt_pop,
    input wire logic rt_save_done,
    output logic [31:0] rt_pop_data,
    output logic rt_pop_valid,
    output logic rt_ecc_fixed,
    output logic [SP_W-1:0] rt_stack_pointer,
    output logic rt_warn_hit,
    output logic rt_max_hit,
    output logic regs_zero
);
    import ilag_pkg::*;

    localparam int LN_W = $clog2(NLINE);
    localparam int PW = 6;
    localparam int DW_C = 32 + PW;
    localparam int IX_W = $clog2(RT_DEPTH);
    localparam logic [SP_W-1:0] RT_MAX = SP_W'(RT_DEPTH - 1);
    localparam logic [SP_W-1:0] RT_FULL = SP_W'(RT_DEPTH);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ilag_line_cfg_t cfg_q [NLINE];
    ilag_line_cfg_t cfg_d [NLINE];
    logic [`ILAG_STK_W-1:0] lmap_q [NLINK];
    logic [`ILAG_STK_W-1:0] lmap_d [NLINK];
    logic [`ILAG_ZONE_W-1:0] zmap_q [NSTACK];
    logic [`ILAG_ZONE_W-1:0] zmap_d [NSTACK];
    logic [SP_W-1:0] warn_q, warn_d;
    logic [`ILAG_STK_W-1:0] stksel_q, stksel_d;
    ilag_map_state_t map_q, map_d;
    logic [NLINE-1:0] en_q, en_d, flag_q, flag_d, ovf_q, ovf_d;
    logic [DW_C-1:0] rt_mem_q [RT_DEPTH];
    logic [SP_W-1:0] sp_q, sp_d;
    logic [31:0] pop_data_q, pop_data_d, prdata_q, prdata_d, vec_q, vec_d;
    logic pop_valid_q, pop_valid_d, fix_q, fix_d;
    logic [NLINE-1:0] pend_q, pend_d;
    logic take_q, take_d, caller_q, caller_d, dbg_q, dbg_d;
    logic warn_hit_q, warn_hit_d, max_hit_q, max_hit_d, zero_q, zero_d;

    // ------------------------------------------------------------------
    // Bus decode and permission
    // ------------------------------------------------------------------
    logic setup, access, hit, allow, is_root, wr_en, push_ok, pop_ok;
    logic [LN_W-1:0] cl, ol;
    logic [3:0] mi;
    logic [31:0] rd_val;
    logic [DW_C-1:0] enc_word;
    logic [31:0] dec_data;
    logic dec_fixed;
    logic [`ILAG_STK_W-1:0] cur_stack;
    logic [IX_W-1:0] top_idx;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign is_root = (cpu_ctx.cur_link == ROOT_LINK);
    assign cl = paddr[LN_W+2:3];
    assign ol = paddr[LN_W+1:2];
    assign mi = paddr[5:2];
    assign cur_stack = lmap_q[cpu_ctx.cur_link];

    // Address map; the real-time stack has no bus window at all
    always_comb begin
        hit = 1'b0;
        allow = 1'b0;
        rd_val = '0;
        if (paddr == `ILAG_OFF_WARN) begin
            hit = 1'b1;
            allow = is_root | ~pwrite;
            rd_val = 32'(warn_q);
        end else if (paddr == `ILAG_OFF_MAX) begin
            hit = 1'b1;
            allow = ~pwrite;
            rd_val = 32'(RT_MAX);
        end else if (paddr == `ILAG_OFF_STAT) begin
            hit = 1'b1;
            allow = ~pwrite;
            rd_val = 32'(sp_q);
            rd_val[`ILAG_STAT_WARN] = warn_hit_q;
            rd_val[`ILAG_STAT_MAX] = max_hit_q;
            rd_val[`ILAG_STAT_LOCK] = (map_q == ILAG_MAP_LOCKED);
        end else if (paddr == `ILAG_OFF_STKSEL) begin
            hit = 1'b1;
            allow = is_root;
            rd_val = 32'(stksel_q);
            rd_val[`ILAG_STKSEL_LOCK] = (map_q == ILAG_MAP_LOCKED);
        end else if (paddr[11:6] == `ILAG_RGN_LMAP && int'(mi) < NLINK) begin
            hit = 1'b1;
            allow = is_root & (~pwrite | map_q == ILAG_MAP_OPEN);
            rd_val = 32'(lmap_q[mi]);
        end else if (paddr[11:6] == `ILAG_RGN_ZMAP && int'(mi) < NSTACK) begin
            hit = 1'b1;
            allow = is_root & (~pwrite | map_q == ILAG_MAP_OPEN);
            rd_val = 32'(zmap_q[mi]);
        end else if (paddr[11:8] == `ILAG_RGN_CFG && int'(paddr[7:3]) < NLINE) begin
            hit = 1'b1;
            allow = is_root;
            rd_val = paddr[2] ? cfg_q[cl].vector : {16'h0000, cfg_q[cl].prio,
                     cfg_q[cl].caller, cfg_q[cl].owner};
        end else if (paddr[11:8] == `ILAG_RGN_OPS && int'(paddr[7:2]) < NLINE) begin
            hit = 1'b1;
            allow = (cpu_ctx.cur_link == cfg_q[ol].owner);
            rd_val[`ILAG_OPS_EN] = en_q[ol];
            rd_val[`ILAG_OPS_FLAG] = flag_q[ol];
            rd_val[`ILAG_OPS_OVF] = ovf_q[ol];
        end
    end

    assign wr_en = ce & access & pwrite & hit & allow;
    assign pready = access;
    assign pslverr = access & ~(hit & allow);
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // Configuration, maps and levels
    // ------------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        lmap_d = lmap_q;
        zmap_d = zmap_q;
        warn_d = warn_q;
        stksel_d = stksel_q;
        map_d = map_q;
        if (wr_en) begin
            if (paddr == `ILAG_OFF_WARN) begin
                warn_d = pwdata[SP_W-1:0];
            end else if (paddr == `ILAG_OFF_STKSEL) begin
                stksel_d = pwdata[`ILAG_STK_W-1:0];
                if (pwdata[`ILAG_STKSEL_LOCK]) begin
                    map_d = ILAG_MAP_LOCKED;
                end
            end else if (paddr[11:6] == `ILAG_RGN_LMAP) begin
                lmap_d[mi] = pwdata[`ILAG_STK_W-1:0];
            end else if (paddr[11:6] == `ILAG_RGN_ZMAP) begin
                zmap_d[mi] = pwdata[`ILAG_ZONE_W-1:0];
            end else if (paddr[11:8] == `ILAG_RGN_CFG && paddr[2]) begin
                cfg_d[cl].vector = pwdata;
            end else if (paddr[11:8] == `ILAG_RGN_CFG) begin
                cfg_d[cl].owner = pwdata[`ILAG_CFG_OWNER_LO +: `ILAG_LINK_W];
                cfg_d[cl].caller = pwdata[`ILAG_CFG_CALLER_LO +: `ILAG_LINK_W];
                cfg_d[cl].prio = pwdata[`ILAG_CFG_PRIO_LO +: `ILAG_PRIO_W];
            end
        end
    end

    // Register the configuration group
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_q <= '{default: '0};
            lmap_q <= '{default: '0};
            zmap_q <= '{default: '0};
            warn_q <= SP_W'(`ILAG_WARN_RST);
            stksel_q <= `ILAG_STKSEL_RST;
            map_q <= ILAG_MAP_OPEN;
        end else if (ce) begin
            cfg_q <= cfg_d;
            lmap_q <= lmap_d;
            zmap_q <= zmap_d;
            warn_q <= warn_d;
            stksel_q <= stksel_d;
            map_q <= map_d;
        end
    end

    // ------------------------------------------------------------------
    // Per-line enable, flag and overflow; an event beats a clear
    // ------------------------------------------------------------------
    always_comb begin
        en_d = en_q;
        flag_d = flag_q;
        ovf_d = ovf_q;
        if (wr_en && paddr[11:8] == `ILAG_RGN_OPS) begin
            en_d[ol] = pwdata[`ILAG_OPS_EN];
            if (pwdata[`ILAG_OPS_CLR]) begin
                flag_d[ol] = 1'b0;
            end
            if (pwdata[`ILAG_OPS_OVCLR]) begin
                ovf_d[ol] = 1'b0;
            end
            if (pwdata[`ILAG_OPS_FORCE]) begin
                flag_d[ol] = 1'b1;
            end
        end
        for (int i = 0; i < NLINE; i++) begin
            if (irq_event[i]) begin
                ovf_d[i] = ovf_d[i] | flag_q[i];
                flag_d[i] = 1'b1;
            end
        end
    end

    // Register the line state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_q <= '0;
            flag_q <= '0;
            ovf_q <= '0;
        end else if (ce) begin
            en_q <= en_d;
            flag_q <= flag_d;
            ovf_q <= ovf_d;
        end
    end

    // ------------------------------------------------------------------
    // Hidden real-time context stack, ECC on every stored frame word
    // ------------------------------------------------------------------
    ilag_ecc_enc #(.DW(32), .PW(PW)) u_enc (
        .data(rt_push_data),
        .code(enc_word)
    );

    // Topmost frame word; only read when the stack is not empty
    assign top_idx = IX_W'(sp_q - 1'b1);

    ilag_ecc_dec #(.DW(32), .PW(PW)) u_dec (
        .code(rt_mem_q[top_idx]),
        .data(dec_data),
        .fixed(dec_fixed)
    );

    assign push_ok = rt_push & (sp_q < RT_FULL);
    assign pop_ok = rt_pop & ~rt_push & (sp_q != '0);

    always_comb begin
        sp_d = sp_q;
        pop_data_d = pop_data_q;
        pop_valid_d = 1'b0;
        fix_d = 1'b0;
        if (push_ok) begin
            sp_d = sp_q + 1'b1;
        end else if (pop_ok) begin
            sp_d = sp_q - 1'b1;
            pop_data_d = dec_data;
            pop_valid_d = 1'b1;
            fix_d = dec_fixed;
        end
    end

    // Register the stack; frame memory itself carries no reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sp_q <= '0;
            pop_data_q <= '0;
            pop_valid_q <= 1'b0;
            fix_q <= 1'b0;
        end else if (ce) begin
            sp_q <= sp_d;
            pop_data_q <= pop_data_d;
            pop_valid_q <= pop_valid_d;
            fix_q <= fix_d;
        end
    end

    // Frame store, written only by the CPU's push path
    always_ff @(posedge ref_clk) begin
        if (ce && !rst && push_ok) begin
            rt_mem_q[sp_q[$clog2(RT_DEPTH)-1:0]] <= enc_word;
        end
    end

    // ------------------------------------------------------------------
    // Registered status outputs and read data
    // ------------------------------------------------------------------
    always_comb begin
        pend_d = flag_q & en_q;
        take_d = std_int_req & (cur_stack == stksel_q);
        caller_d = (cpu_ctx.caller_link == cfg_q[isr_line].owner);
        dbg_d = (zmap_q[cur_stack] == dbg_zone);
        warn_hit_d = (sp_q >= warn_q);
        max_hit_d = (sp_q >= RT_MAX);
        zero_d = rt_save_done & (cpu_ctx.int_state == ILAG_ST_RT ||
                 cpu_ctx.int_state == ILAG_ST_NMI);
        vec_d = cfg_q[isr_line].vector;
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = (hit & allow & ~pwrite) ? rd_val : '0;
        end
    end

    // Register the outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_q <= '0;
            {take_q, caller_q, dbg_q, warn_hit_q, max_hit_q, zero_q} <= '0;
            vec_q <= '0;
            prdata_q <= '0;
        end else if (ce) begin
            pend_q <= pend_d;
            {take_q, caller_q, dbg_q} <= {take_d, caller_d, dbg_d};
            {warn_hit_q, max_hit_q, zero_q} <= {warn_hit_d, max_hit_d, zero_d};
            vec_q <= vec_d;
            prdata_q <= prdata_d;
        end
    end

    assign irq_pending = pend_q;
    assign isr_vector = vec_q;
    assign caller_match = caller_q;
    assign std_int_take = take_q;
    assign dbg_allow = dbg_q;
    assign rt_pop_data = pop_data_q;
    assign rt_pop_valid = pop_valid_q;
    assign rt_ecc_fixed = fix_q;
    assign rt_stack_pointer = sp_q;
    assign rt_warn_hit = warn_hit_q;
    assign rt_max_hit = max_hit_q;
    assign regs_zero = zero_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_push;
        ce && rt_push && sp_q < RT_FULL;
    endsequence
    sequence s_pop_next;
        ce && rt_pop && !rt_push;
    endsequence
    sequence s_denied_rd;
        ce && setup && !pwrite && !(hit && allow);
    endsequence

    a_cfg_root_only: assert property (access && paddr[11:8] == `ILAG_RGN_CFG && !is_root
        |-> pslverr) else $error("config access from non-root not refused");
    a_ops_owner_only: assert property (access && hit && paddr[11:8] == `ILAG_RGN_OPS &&
        cpu_ctx.cur_link != cfg_q[ol].owner |-> pslverr)
        else $error("line access from non-owner not refused");
    a_denied_reads_zero: assert property (s_denied_rd |=> prdata == 32'h0)
        else $error("denied read returned data");
    a_warn_write_guard: assert property (ce && access && pwrite &&
        paddr == `ILAG_OFF_WARN && !is_root |=> warn_q == $past(warn_q))
        else $error("warning level changed by non-root");
    a_max_fault_level: assert property (ce && sp_q == RT_MAX |=> rt_max_hit)
        else $error("maximum level not flagged");
    a_std_int_hold: assert property (ce && std_int_req && cur_stack != stksel_q
        |=> !std_int_take) else $error("standard interrupt taken off its stack");
    a_zero_after_save: assert property (ce && rt_save_done &&
        cpu_ctx.int_state == ILAG_ST_NMI |=> regs_zero)
        else $error("registers not zeroed after save");
    a_caller_check: assert property (ce && cpu_ctx.caller_link != cfg_q[isr_line].owner
        |=> !caller_match) else $error("caller mismatch not reported");
    a_event_sets_flag: assert property (ce && irq_event[0] |=> flag_q[0])
        else $error("event lost against clear");
    a_map_stays_locked: assert property (map_q == ILAG_MAP_LOCKED |=> map_q == ILAG_MAP_LOCKED)
        else $error("stack map unlocked");
    a_frame_round_trip: assert property (s_push ##1 s_pop_next |=>
        rt_pop_valid && rt_pop_data == $past(rt_push_data, 2))
        else $error("frame lost on stack round trip");
endmodule

//--- tb/ilag_xp_mdl.sv
/*
 * Expander-side model that reacts to the guard's stack level flags.
 * Assumes the flags are registered on ref_clk.
 */
`timescale 1ns/1ps
module ilag_xp_mdl (
    // Level flags from the guard
    input wire logic rt_warn_hit,
    input wire logic rt_max_hit,
    // Decisions toward the CPU
    output logic rt_fwd_ok,
    output logic nmi_req
);
    // Throttle real-time forwarding, escalate at the maximum level (one below full)
    assign rt_fwd_ok = !rt_warn_hit;
    assign nmi_req = rt_max_hit;
endmodule

//--- tb/ilag_guard_tb.sv
/*
 * Self-checking bench of ilag_guard: APB access, context, stack.
 * Assumes zero-wait APB and one-cycle registered outputs.
 */
`timescale 1ns/1ps
module ilag_guard_tb;
    import ilag_pkg::*;
    typedef struct packed {
        logic w;
        logic [3:0] l;
        logic [11:0] a;
        logic [15:0] d;
        logic e;
        logic [15:0] x;
    } ilag_row_t;
    // ----
    // Signals
    // ----
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rt_push_data = 32'h0;
    ilag_cpu_ctx_t cpu_ctx = '0;
    logic [2:0] isr_line = 3'h0;
    logic [1:0] dbg_zone = 2'h1;
    logic [7:0] irq_event = 8'h00;
    logic std_int_req = 1'b0;
    logic rt_push = 1'b0;
    logic rt_pop = 1'b0;
    logic rt_save_done = 1'b0;
    logic pready, pslverr, caller_match, std_int_take, dbg_allow, err;
    logic rt_pop_valid, rt_ecc_fixed, rt_warn_hit, rt_max_hit, regs_zero;
    logic rt_fwd_ok, nmi_req;
    logic [7:0] irq_pending, rt_stack_pointer;
    logic [31:0] prdata, isr_vector, rt_pop_data, rd;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    ilag_row_t rows [16] = '{
        '{1'b0, 4'h5, 12'h004, 16'h0, 1'b0, 16'h000f},
        '{1'b1, 4'h0, 12'h100, 16'h3305, 1'b0, 16'h0},
        '{1'b1, 4'h5, 12'h100, 16'h00ff, 1'b1, 16'h0},
        '{1'b0, 4'h0, 12'h100, 16'h0, 1'b0, 16'h3305},
        '{1'b1, 4'h0, 12'h104, 16'habcd, 1'b0, 16'h0},
        '{1'b0, 4'h5, 12'h104, 16'h0, 1'b1, 16'h0},
        '{1'b1, 4'h5, 12'h200, 16'h0101, 1'b0, 16'h0},
        '{1'b0, 4'h5, 12'h200, 16'h0, 1'b0, 16'h3},
        '{1'b0, 4'h1, 12'h200, 16'h0, 1'b1, 16'h0},
        '{1'b1, 4'h5, 12'h200, 16'h0201, 1'b0, 16'h0},
        '{1'b1, 4'h5, 12'h000, 16'h3, 1'b1, 16'h0},
        '{1'b1, 4'h0, 12'h000, 16'h3, 1'b0, 16'h0},
        '{1'b1, 4'h0, 12'h054, 16'h2, 1'b0, 16'h0},
        '{1'b1, 4'h0, 12'h088, 16'h1, 1'b0, 16'h0},
        '{1'b1, 4'h0, 12'h00c, 16'h0102, 1'b0, 16'h0},
        '{1'b1, 4'h0, 12'h054, 16'h3, 1'b1, 16'h0}
    };
    ilag_guard u_ilag_guard (.ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .cpu_ctx, .isr_line, .std_int_req,
        .dbg_zone, .irq_event, .irq_pending, .isr_vector, .caller_match,
        .std_int_take, .dbg_allow, .rt_push, .rt_push_data, .rt_pop, .rt_save_done,
        .rt_pop_data, .rt_pop_valid, .rt_ecc_fixed, .rt_stack_pointer,
        .rt_warn_hit, .rt_max_hit, .regs_zero);
    ilag_xp_mdl u_ilag_xp_mdl (.rt_warn_hit, .rt_max_hit, .rt_fwd_ok, .nmi_req);
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, x);
        end
    endtask
    // One APB transfer as link l
    task automatic apb(input logic w, input logic [3:0] l, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        cpu_ctx.cur_link <= l;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].l, rows[i].a, {16'h0, rows[i].d});
            chk(32'(err), 32'(rows[i].e));
            if (!rows[i].w) chk(rd, {16'h0, rows[i].x});
        end
        @(posedge ref_clk);
        cpu_ctx <= '{4'h5, 4'h5, ILAG_ST_MAIN};
        std_int_req <= 1'b1;
        irq_event <= 8'h01;
        repeat (2) @(posedge ref_clk);
        irq_event <= 8'h00;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(32'(std_int_take), 32'h1);
        chk(32'(dbg_allow), 32'h1);
        chk(32'(caller_match), 32'h1);
        chk(isr_vector, 32'habcd);
        chk(32'(irq_pending), 32'h1);
        apb(1'b0, 4'h5, 12'h200, 32'h0);
        chk(rd, 32'h7);
        @(posedge ref_clk);
        cpu_ctx <= '{4'h1, 4'h1, ILAG_ST_RT};
        repeat (2) @(posedge ref_clk);
        #1;
        chk(32'(std_int_take), 32'h0);
        chk(32'(caller_match), 32'h0);
        @(posedge ref_clk);
        for (int i = 0; i < 15; i++) begin
            rt_push <= 1'b1;
            rt_push_data <= 32'hc0de0000 + 32'(i);
            @(posedge ref_clk);
        end
        rt_push <= 1'b0;
        rt_save_done <= 1'b1;
        @(posedge ref_clk);
        rt_save_done <= 1'b0;
        #1;
        chk(32'(regs_zero), 32'h1);
        chk(32'({rt_fwd_ok, nmi_req}), 32'h1);
        chk(32'(rt_stack_pointer), 32'hf);
        @(posedge ref_clk);
        rt_pop <= 1'b1;
        @(posedge ref_clk);
        rt_pop <= 1'b0;
        #1;
        chk(rt_pop_data, 32'hc0de000e);
        chk(32'({rt_pop_valid, rt_ecc_fixed}), 32'h2);
        @(posedge ref_clk);
        rt_push <= 1'b1;
        rt_push_data <= 32'h5a5a0001;
        @(posedge ref_clk);
        rt_push <= 1'b0;
        rt_pop <= 1'b1;
        @(posedge ref_clk);
        rt_pop <= 1'b0;
        #1;
        chk(rt_pop_data, 32'h5a5a0001);
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, 4'h5, 12'h000, 32'h0);
        chk(rd, 32'hff);
        complete_run();
    end
endmodule
